// ==== verilog/wrc_pkg.sv ====
// Package: constants for the watchdog and reset-cause block.
// Assumes an 8-bit special function register port with page select.
package wrc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] WDOG_CTRL_ADDR = 8'hFF;
  localparam logic [7:0] RST_CAUSE_ADDR = 8'hEF;
  localparam logic [7:0] RST_CAUSE_PAGE = 8'h00;

  // ----------------------------------------------------------------
  // Watchdog control commands and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ENABLE = 8'hA5;
  localparam logic [7:0] CMD_DIS_FIRST = 8'hDE;
  localparam logic [7:0] CMD_DIS_SECOND = 8'hAD;
  localparam logic [7:0] CMD_LOCK = 8'hFF;
  localparam int WD_SEL_LSB = 0;
  localparam int WD_SEL_W = 3;
  localparam int WD_STATUS_BIT = 4;
  localparam int WD_CMD_BIT = 7;
  localparam logic [2:0] WD_SEL_RESET = 3'h7;
  localparam int WD_CNT_W = 21;
  localparam int WD_EXP_BASE = 3;
  localparam logic [2:0] DIS_WINDOW_CLKS = 3'h4;

  // ----------------------------------------------------------------
  // Reset-cause fields
  // ----------------------------------------------------------------
  localparam int RC_PIN_BIT = 0;
  localparam int RC_POR_BIT = 1;
  localparam int RC_MCD_BIT = 2;
  localparam int RC_WDOG_BIT = 3;
  localparam int RC_SW_BIT = 4;
  localparam int RC_CMP_BIT = 5;
  localparam int RC_CNV_BIT = 6;
  localparam logic [7:0] RST_CAUSE_RESET = 8'h00;

endpackage : wrc_pkg

// ==== verilog/wrc_sync2.sv ====
// Two-flop synchroniser for asynchronous pin levels.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module wrc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  always_comb begin
    next_stage1 = srst_i ? RST_VAL : async_i;
    next_sync = srst_i ? RST_VAL : stage1;
  end

  always_ff @(posedge core_clk_i) begin
    stage1 <= next_stage1;
    sync_o <= next_sync;
  end
endmodule : wrc_sync2

// ==== verilog/wrc_wdt_count.sv ====
// Watchdog interval counter with power-of-four timeout select.
// Assumes the owner restarts it on reset and on the enable command.
`timescale 1ns/1ns
module wrc_wdog_count #(
  parameter int CNT_W = 21,
  parameter int EXP_BASE = 3
) (
  input wire logic core_clk_i,
  input wire logic restart_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  output logic [CNT_W-1:0] count_o,
  output logic expire_o
);
  logic [CNT_W-1:0] next_count;

  // Last count before timeout: 4^(base+sel) - 1
  function automatic logic [CNT_W-1:0] last_count(input logic [2:0] sel);
    int sh;
    sh = 2 * (EXP_BASE + int'(sel));
    last_count = CNT_W'((64'(1) << sh) - 64'(1));
  endfunction : last_count

  assign expire_o = run_i && (count_o == last_count(sel_i));

  always_comb begin
    next_count = count_o;
    if (restart_i || expire_o) begin
      next_count = '0;
    end else if (run_i) begin
      next_count = count_o + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    count_o <= next_count;
  end
endmodule : wrc_wdog_count

// ==== verilog/wrc_top.sv ====
// Watchdog timer and reset-cause register behind the SFR port.
// Assumes the reset controller holds srst_i while any reset source
// acts and presents the external cause levels during srst_i.
//
// Behaviour
// - Control register bits 2:0 select the watchdog timeout interval.
// - Timeout is 4 to the power (3 plus selector) clock periods.
// - Reading the control register returns the selector in bits 2:0.
// - Selector reads all ones after any system reset.
// - Writing 0xA5 enables the watchdog and restarts it from zero.
// - Disable needs 0xDE then 0xAD within four clocks, else ignored.
// - Writing 0xFF blocks any later disable sequence until the next system reset.
// - Control bit 4 reads one while the watchdog runs.
// - Control register sits at 0xFF on every register page.
// - Reset-cause bit 6 enables the active-low convert-start reset.
// - Power-on reset sets the power-on flag; other resets clear it.
// - Leaving an external pin reset sets the pin flag in bit 0.
// - Bit 2 enables missing clock detector; reads one after its reset.
// - Any system reset leaves the watchdog enabled, counting from zero.
`timescale 1ns/1ns
module wrc_top #(
  parameter int WD_CNT_W = wrc_pkg::WD_CNT_W,
  parameter int WD_EXP_BASE = wrc_pkg::WD_EXP_BASE
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_page_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic por_cause_i,
  input wire logic pin_cause_i,
  input wire logic mcd_cause_i,
  input wire logic convert_start_input_n_i,
  input wire logic cmp_reset_n_i,
  output logic sys_reset_req_o,
  output logic missing_clock_enable_o,
  output logic supply_monitor_select_o,
  output logic convert_start_reset_enable_o,
  output logic watchdog_active_o
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic sfr_hit(input logic [7:0] addr,
                                   input logic [7:0] page,
                                   input logic [7:0] reg_addr,
                                   input logic [7:0] reg_page,
                                   input logic all_pages);
    sfr_hit = (addr == reg_addr) && (all_pages || page == reg_page);
  endfunction : sfr_hit

  logic wd_sel;
  logic rc_sel;
  logic wr_wd;
  logic wr_rc;

  assign wd_sel = sfr_hit(sfr_addr_i, sfr_page_i, wrc_pkg::WDOG_CTRL_ADDR,
                          8'h00, 1'b1);
  assign rc_sel = sfr_hit(sfr_addr_i, sfr_page_i, wrc_pkg::RST_CAUSE_ADDR,
                          wrc_pkg::RST_CAUSE_PAGE, 1'b0);
  assign wr_wd = sfr_wr_i && wd_sel;
  assign wr_rc = sfr_wr_i && rc_sel;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pins_s;
  logic cnv_n_s;
  logic cmp_n_s;

  wrc_sync2 #(.W(2), .RST_VAL(2'h3)) u_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i({cmp_reset_n_i, convert_start_input_n_i}),
    .sync_o(pins_s)
  );
  assign cnv_n_s = pins_s[0];
  assign cmp_n_s = pins_s[1];

  // ----------------------------------------------------------------
  // Watchdog control state
  // ----------------------------------------------------------------
  logic [2:0] sel;
  logic wd_en;
  logic lock;
  logic [2:0] win;
  logic [2:0] next_sel;
  logic next_wd_en;
  logic next_lock;
  logic [2:0] next_win;
  logic restart;
  logic wd_fire;
  logic [WD_CNT_W-1:0] wd_count;

  always_comb begin
    next_sel = sel;
    next_wd_en = wd_en;
    next_lock = lock;
    next_win = (win == 3'h0) ? 3'h0 : win - 3'h1;
    restart = 1'b0;
    if (wr_wd) begin
      if (!sfr_wdata_i[wrc_pkg::WD_CMD_BIT]) begin
        next_sel =
          sfr_wdata_i[wrc_pkg::WD_SEL_LSB +: wrc_pkg::WD_SEL_W];
      end
      case (sfr_wdata_i)
        wrc_pkg::CMD_ENABLE: begin
          next_wd_en = 1'b1;
          restart = 1'b1;
        end
        wrc_pkg::CMD_DIS_FIRST: begin
          next_win = wrc_pkg::DIS_WINDOW_CLKS;
        end
        wrc_pkg::CMD_DIS_SECOND: begin
          if (win != 3'h0 && !lock) begin
            next_wd_en = 1'b0;
          end
          next_win = 3'h0;
        end
        wrc_pkg::CMD_LOCK: begin
          next_lock = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (srst_i) begin
      next_sel = wrc_pkg::WD_SEL_RESET;
      next_wd_en = 1'b1;
      next_lock = 1'b0;
      next_win = 3'h0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    sel <= next_sel;
    wd_en <= next_wd_en;
    lock <= next_lock;
    win <= next_win;
  end

  wrc_wdog_count #(.CNT_W(WD_CNT_W), .EXP_BASE(WD_EXP_BASE)) u_cnt (
    .core_clk_i(core_clk_i),
    .restart_i(restart || srst_i),
    .run_i(wd_en && !srst_i),
    .sel_i(sel),
    .count_o(wd_count),
    .expire_o(wd_fire)
  );

  assign watchdog_active_o = wd_en;

  // ----------------------------------------------------------------
  // Reset-cause state
  // ----------------------------------------------------------------
  // Source order in src and last_src, from bit 0 up: wdog, sw, cmp, cnv
  logic mcd_en;
  logic cmp_en;
  logic cnv_en;
  logic mon_sel;
  logic [6:0] flags;
  logic req;
  logic srst_q;
  logic [3:0] last_src;
  logic next_mcd_en;
  logic next_cmp_en;
  logic next_cnv_en;
  logic next_mon_sel;
  logic [6:0] next_flags;
  logic next_req;
  logic [3:0] next_last_src;
  logic [3:0] src;

  always_comb begin
    src[0] = wd_fire;
    src[1] = wr_rc && sfr_wdata_i[wrc_pkg::RC_SW_BIT];
    src[2] = cmp_en && !cmp_n_s;
    src[3] = cnv_en && !cnv_n_s;
    next_mcd_en = mcd_en;
    next_cmp_en = cmp_en;
    next_cnv_en = cnv_en;
    next_mon_sel = mon_sel;
    next_flags = flags;
    next_req = req || (|src);
    next_last_src = last_src;
    if (!req && (|src)) begin
      next_last_src = src;
    end
    if (srst_q && !srst_i) begin
      next_last_src = 4'h0;
    end
    if (wr_rc) begin
      next_cnv_en = sfr_wdata_i[wrc_pkg::RC_CNV_BIT];
      next_cmp_en = sfr_wdata_i[wrc_pkg::RC_CMP_BIT];
      next_mcd_en = sfr_wdata_i[wrc_pkg::RC_MCD_BIT];
      next_mon_sel = sfr_wdata_i[wrc_pkg::RC_POR_BIT];
    end
    if (srst_i) begin
      next_flags = 7'h00;
      next_flags[wrc_pkg::RC_POR_BIT] = por_cause_i;
      if (!por_cause_i) begin
        next_flags[wrc_pkg::RC_PIN_BIT] = pin_cause_i;
        next_flags[wrc_pkg::RC_MCD_BIT] = mcd_cause_i;
        next_flags[wrc_pkg::RC_WDOG_BIT] = last_src[0];
        next_flags[wrc_pkg::RC_SW_BIT] = last_src[1];
        next_flags[wrc_pkg::RC_CMP_BIT] = last_src[2];
        next_flags[wrc_pkg::RC_CNV_BIT] = last_src[3];
      end
      next_last_src = por_cause_i ? 4'h0 : last_src;
      next_mcd_en = wrc_pkg::RST_CAUSE_RESET[wrc_pkg::RC_MCD_BIT];
      next_cmp_en = wrc_pkg::RST_CAUSE_RESET[wrc_pkg::RC_CMP_BIT];
      next_cnv_en = wrc_pkg::RST_CAUSE_RESET[wrc_pkg::RC_CNV_BIT];
      next_mon_sel = 1'b1;
      next_req = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    mcd_en <= next_mcd_en;
    cmp_en <= next_cmp_en;
    cnv_en <= next_cnv_en;
    mon_sel <= next_mon_sel;
    flags <= next_flags;
    req <= next_req;
    srst_q <= srst_i;
    last_src <= next_last_src;
  end

  assign sys_reset_req_o = req;
  assign missing_clock_enable_o = mcd_en;
  assign supply_monitor_select_o = mon_sel;
  assign convert_start_reset_enable_o = cnv_en;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] wd_view;
  logic [7:0] next_rdata;

  always_comb begin
    wd_view = 8'h00;
    wd_view[wrc_pkg::WD_SEL_LSB +: wrc_pkg::WD_SEL_W] = sel;
    wd_view[wrc_pkg::WD_STATUS_BIT] = wd_en;
    next_rdata = sfr_rdata_o;
    if (sfr_rd_i) begin
      if (wd_sel) begin
        next_rdata = wd_view;
      end else if (rc_sel) begin
        next_rdata = {1'b0, flags};
      end else begin
        next_rdata = 8'h00;
      end
    end
    if (srst_i) begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge core_clk_i) begin
    sfr_rdata_o <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SEL_RESET: assert property (@(posedge core_clk_i)
    srst_i |=> sel == 3'h7)
    else $error("selector not all ones after reset");

  AST_RESET_RUNS: assert property (@(posedge core_clk_i)
    srst_i ##1 !srst_i |-> wd_en && wd_count == '0 ##1 wd_count == 1)
    else $error("watchdog not enabled and restarted after reset");

  AST_ENABLE: assert property (@(posedge core_clk_i)
    disable iff (srst_i) wr_wd && sfr_wdata_i == wrc_pkg::CMD_ENABLE |=>
    wd_en && wd_count == '0)
    else $error("enable command did not restart watchdog");

  AST_DISABLE: assert property (@(posedge core_clk_i)
    disable iff (srst_i)
    (wr_wd && sfr_wdata_i == wrc_pkg::CMD_DIS_FIRST && !lock) ##[1:4]
    (wr_wd && sfr_wdata_i == wrc_pkg::CMD_DIS_SECOND && !lock) |=> !wd_en)
    else $error("disable pair within four clocks ignored");

  AST_DISABLE_LATE: assert property (@(posedge core_clk_i)
    disable iff (srst_i) wd_en && win == 3'h0 && wr_wd &&
    sfr_wdata_i == wrc_pkg::CMD_DIS_SECOND |=> wd_en)
    else $error("late second disable byte took effect");

  AST_LOCK_HOLDS: assert property (@(posedge core_clk_i)
    disable iff (srst_i) lock && wd_en |=> lock && wd_en)
    else $error("locked watchdog was disabled");

  AST_LOCK_NO_RELOAD: assert property (@(posedge core_clk_i)
    disable iff (srst_i) wr_wd && sfr_wdata_i == wrc_pkg::CMD_LOCK &&
    !wd_en |=> !wd_en && lock)
    else $error("lock write enabled the watchdog");

  AST_READ_WD: assert property (@(posedge core_clk_i)
    disable iff (srst_i) sfr_rd_i && sfr_addr_i == wrc_pkg::WDOG_CTRL_ADDR |=>
    sfr_rdata_o == {3'h0, $past(wd_en), 1'b0, $past(sel)})
    else $error("control read shows wrong status or selector");

  AST_FIRE_TIME: assert property (@(posedge core_clk_i)
    disable iff (srst_i) wd_fire |->
    int'(wd_count) == 4 ** (WD_EXP_BASE + int'(sel)) - 1)
    else $error("watchdog expired at wrong count");

  AST_FIRE_REQ: assert property (@(posedge core_clk_i)
    disable iff (srst_i) wd_fire |=>
    sys_reset_req_o && (last_src[0] || $past(req)))
    else $error("timeout did not request reset");

  AST_CNV_REQ: assert property (@(posedge core_clk_i)
    disable iff (srst_i) cnv_en && !cnv_n_s |=> sys_reset_req_o)
    else $error("enabled convert start input did not request reset");

  AST_POR_FLAG: assert property (@(posedge core_clk_i)
    srst_i |=> flags[1] == $past(por_cause_i) &&
    (!flags[1] || flags[6:2] == 5'h00 && !flags[0]))
    else $error("power-on flag capture wrong");

  AST_CAUSE_FLAGS: assert property (@(posedge core_clk_i)
    srst_i && !por_cause_i |=> flags[0] == $past(pin_cause_i) &&
    flags[2] == $past(mcd_cause_i) && flags[3] == $past(last_src[0]))
    else $error("reset cause flags not captured");

endmodule : wrc_top

// ==== sim/tb_top.sv ====
// Testbench for the watchdog and reset-cause block.
// Drives the register port, reset and cause levels directly.
`timescale 1ns/1ns
module tb_top;
  // --------------------------------------------------------------
  // Clock, reset and design
  // --------------------------------------------------------------
  localparam int EXP_BASE = wrc_pkg::WD_EXP_BASE;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_page_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic por_cause_i = 1'b1;
  logic pin_cause_i = 1'b0;
  logic mcd_cause_i = 1'b0;
  logic convert_start_input_n_i = 1'b1;
  logic sys_reset_req_o;
  logic missing_clock_enable_o;
  logic supply_monitor_select_o;
  logic convert_start_reset_enable_o;
  logic watchdog_active_o;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic [7:0] rv;

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) cyc <= cyc + 1;

  wrc_top #(.WD_CNT_W(wrc_pkg::WD_CNT_W), .WD_EXP_BASE(EXP_BASE)) i_dut (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .sfr_addr_i(sfr_addr_i),
    .sfr_page_i(sfr_page_i),
    .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o),
    .por_cause_i(por_cause_i),
    .pin_cause_i(pin_cause_i),
    .mcd_cause_i(mcd_cause_i),
    .convert_start_input_n_i(convert_start_input_n_i),
    .cmp_reset_n_i(1'b1),
    .sys_reset_req_o(sys_reset_req_o),
    .missing_clock_enable_o(missing_clock_enable_o),
    .supply_monitor_select_o(supply_monitor_select_o),
    .convert_start_reset_enable_o(convert_start_reset_enable_o),
    .watchdog_active_o(watchdog_active_o)
  );

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic do_reset(input logic por, input logic pin,
                          input logic mcd, input int n);
    @(posedge core_clk_i);
    #1;
    srst_i = 1'b1;
    por_cause_i = por;
    pin_cause_i = pin;
    mcd_cause_i = mcd;
    repeat (n) @(posedge core_clk_i);
    #1;
    srst_i = 1'b0;
    por_cause_i = 1'b0;
    pin_cause_i = 1'b0;
    mcd_cause_i = 1'b0;
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] pg,
                    input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    sfr_wr_i = 1'b1;
    sfr_addr_i = a;
    sfr_page_i = pg;
    sfr_wdata_i = d;
    @(posedge core_clk_i);
    #1;
    sfr_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] pg,
                    output logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    sfr_rd_i = 1'b1;
    sfr_addr_i = a;
    sfr_page_i = pg;
    @(posedge core_clk_i);
    #1;
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
  endtask : rd

  task automatic wd(input logic [7:0] d);
    wr(wrc_pkg::WDOG_CTRL_ADDR, 8'h00, d);
  endtask : wd

  task automatic rc_rd(input logic [7:0] exp);
    rd(wrc_pkg::RST_CAUSE_ADDR, wrc_pkg::RST_CAUSE_PAGE, rv);
    chk({8'h00, rv}, {8'h00, exp});
  endtask : rc_rd

  task automatic wait_req(input int start, input int exp_n);
    int i;
    for (i = 0; i < 20000; i++) begin
      if (sys_reset_req_o === 1'b1) break;
      @(posedge core_clk_i);
      #1;
    end
    if (i == 20000) begin
      errors++;
      end_of_test();
    end
    chk(16'(cyc - start), 16'(exp_n));
  endtask : wait_req

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_defaults;
    rd(wrc_pkg::WDOG_CTRL_ADDR, 8'h00, rv);
    chk({8'h00, rv}, 16'h0017);
    chk({15'h0000, watchdog_active_o}, 16'h0001);
    chk({15'h0000, supply_monitor_select_o}, 16'h0001);
    rc_rd(8'h02);
    rd(8'h10, 8'h00, rv);
    chk({8'h00, rv}, 16'h0000);
  endtask : t_defaults

  task automatic t_interval;
    int start;
    wr(wrc_pkg::WDOG_CTRL_ADDR, 8'h0F, 8'h02);
    rd(wrc_pkg::WDOG_CTRL_ADDR, 8'h05, rv);
    chk({8'h00, rv}, 16'h0012);
    wd(8'h83);
    rd(wrc_pkg::WDOG_CTRL_ADDR, 8'h00, rv);
    chk({8'h00, rv}, 16'h0012);
    wd(wrc_pkg::CMD_ENABLE);
    start = cyc;
    wait_req(start, 4 ** (EXP_BASE + 2));
    do_reset(1'b0, 1'b0, 1'b0, 3);
    rc_rd(8'h08);
    rd(wrc_pkg::WDOG_CTRL_ADDR, 8'h00, rv);
    chk({8'h00, rv}, 16'h0017);
  endtask : t_interval

  task automatic t_disable;
    wd(8'h01);
    wd(wrc_pkg::CMD_DIS_FIRST);
    wd(wrc_pkg::CMD_DIS_SECOND);
    chk({15'h0000, watchdog_active_o}, 16'h0000);
    rd(wrc_pkg::WDOG_CTRL_ADDR, 8'h00, rv);
    chk({8'h00, rv}, 16'h0001);
    repeat (300) @(posedge core_clk_i);
    #1;
    chk({15'h0000, sys_reset_req_o}, 16'h0000);
    wd(wrc_pkg::CMD_ENABLE);
    chk({15'h0000, watchdog_active_o}, 16'h0001);
    wd(wrc_pkg::CMD_DIS_FIRST);
    repeat (3) @(posedge core_clk_i);
    wd(wrc_pkg::CMD_DIS_SECOND);
    chk({15'h0000, watchdog_active_o}, 16'h0001);
    wd(wrc_pkg::CMD_ENABLE);
    wd(wrc_pkg::CMD_DIS_FIRST);
    repeat (2) @(posedge core_clk_i);
    wd(wrc_pkg::CMD_DIS_SECOND);
    chk({15'h0000, watchdog_active_o}, 16'h0000);
    wd(wrc_pkg::CMD_LOCK);
    chk({15'h0000, watchdog_active_o}, 16'h0000);
  endtask : t_disable

  task automatic t_lock;
    int start;
    do_reset(1'b0, 1'b0, 1'b0, 3);
    wd(8'h02);
    wd(wrc_pkg::CMD_ENABLE);
    start = cyc;
    wd(wrc_pkg::CMD_LOCK);
    wd(wrc_pkg::CMD_DIS_FIRST);
    wd(wrc_pkg::CMD_DIS_SECOND);
    chk({15'h0000, watchdog_active_o}, 16'h0001);
    wait_req(start, 4 ** (EXP_BASE + 2));
    do_reset(1'b0, 1'b0, 1'b0, 3);
    wd(wrc_pkg::CMD_DIS_FIRST);
    wd(wrc_pkg::CMD_DIS_SECOND);
    chk({15'h0000, watchdog_active_o}, 16'h0000);
  endtask : t_lock

  task automatic t_cause;
    logic [2:0] src [3] = '{3'b100, 3'b010, 3'b001};
    logic [7:0] flg [3] = '{8'h02, 8'h01, 8'h04};
    int i;
    for (i = 0; i < 3; i++) begin
      do_reset(src[i][2], src[i][1], src[i][0], 3);
      rc_rd(flg[i]);
    end
    wr(wrc_pkg::RST_CAUSE_ADDR, wrc_pkg::RST_CAUSE_PAGE, 8'h44);
    wr(wrc_pkg::RST_CAUSE_ADDR, 8'h01, 8'h00);
    chk({15'h0000, convert_start_reset_enable_o}, 16'h0001);
    chk({15'h0000, missing_clock_enable_o}, 16'h0001);
    chk({15'h0000, supply_monitor_select_o}, 16'h0000);
    convert_start_input_n_i = 1'b0;
    for (i = 0; i < 8; i++) begin
      if (sys_reset_req_o === 1'b1) break;
      @(posedge core_clk_i);
      #1;
    end
    chk({15'h0000, sys_reset_req_o}, 16'h0001);
    do_reset(1'b0, 1'b0, 1'b0, 3);
    convert_start_input_n_i = 1'b1;
    rc_rd(8'h40);
    wr(wrc_pkg::RST_CAUSE_ADDR, wrc_pkg::RST_CAUSE_PAGE, 8'h00);
    convert_start_input_n_i = 1'b0;
    repeat (10) @(posedge core_clk_i);
    #1;
    chk({15'h0000, sys_reset_req_o}, 16'h0000);
    convert_start_input_n_i = 1'b1;
    wr(wrc_pkg::RST_CAUSE_ADDR, wrc_pkg::RST_CAUSE_PAGE, 8'h10);
    chk({15'h0000, sys_reset_req_o}, 16'h0001);
    do_reset(1'b0, 1'b0, 1'b0, 3);
    rc_rd(8'h10);
  endtask : t_cause

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk_i);
    #1;
    srst_i = 1'b0;
    por_cause_i = 1'b0;
    t_defaults();
    t_interval();
    t_disable();
    t_lock();
    t_cause();
    end_of_test();
  end
endmodule : tb_top
